// ==== design/sdcs_pkg.sv ====
package sdcs_pkg;
  // socket table size and index width
  localparam int          NSOCK        = 8;
  localparam int          SIDX_W       = 3;
  localparam logic [7:0]  NSOCK_B      = 8'h08;
  // request frame types
  localparam logic [7:0]  T_CONN       = 8'h42;
  localparam logic [7:0]  T_CLOSE      = 8'h43;
  localparam logic [7:0]  T_SEND       = 8'h44;
  // answer frame types
  localparam logic [7:0]  T_CONN_RSP   = 8'hc2;
  localparam logic [7:0]  T_CLOSE_RSP  = 8'hc3;
  localparam logic [7:0]  T_TX_STAT    = 8'h89;
  localparam logic [7:0]  T_SOCK_STAT  = 8'hcf;
  // connect and close status codes
  localparam logic [7:0]  ST_OK        = 8'h00;
  localparam logic [7:0]  ST_BAD_ATYPE = 8'h01;
  localparam logic [7:0]  ST_BAD_PARAM = 8'h02;
  localparam logic [7:0]  ST_IN_PROG   = 8'h03;
  localparam logic [7:0]  ST_ALREADY   = 8'h04;
  localparam logic [7:0]  ST_UNKNOWN   = 8'h05;
  localparam logic [7:0]  ST_BAD_SOCK  = 8'h20;
  // transmit status and socket status codes
  localparam logic [7:0]  TXS_OK       = 8'h00;
  localparam logic [7:0]  TXS_NOT_CONN = 8'h21;
  localparam logic [7:0]  TXS_TOO_LONG = 8'h22;
  localparam logic [7:0]  SS_UP        = 8'h00;
  localparam logic [7:0]  SS_FAIL      = 8'h01;
  // special socket id and address types
  localparam logic [7:0]  SOCK_ALL     = 8'hff;
  localparam logic [7:0]  ATYPE_BIN    = 8'h00;
  localparam logic [7:0]  ATYPE_TEXT   = 8'h01;
  // body byte positions after the socket id of a connect
  localparam logic [10:0] CP_PORT_HI   = 11'h000;
  localparam logic [10:0] CP_PORT_LO   = 11'h001;
  localparam logic [10:0] CP_ATYPE     = 11'h002;
  localparam logic [10:0] CP_ADDR      = 11'h003;
  localparam logic [10:0] CP_BIN_END   = 11'h007;
  // payload limit and counter ceiling
  localparam logic [10:0] MAX_PAYLOAD  = 11'h5dc;
  localparam logic [10:0] IDX_SAT      = 11'h7ff;
  // answer frame lengths
  localparam logic [2:0]  LEN_RSP      = 3'h4;
  localparam logic [2:0]  LEN_TXS      = 3'h3;
  // parser states
  typedef enum logic [2:0] {
    S_TYPE = 3'b000,
    S_REF  = 3'b001,
    S_SOCK = 3'b010,
    S_BODY = 3'b011,
    S_SKIP = 3'b100,
    S_EVAL = 3'b101,
    S_RESP = 3'b110
  } sdcs_state_t;
endpackage

// ==== design/sdcs_skid.sv ====
// two-entry buffer: a stall on the drain side never loses a word
module sdcs_skid #(
  parameter int DW = 9
) (
  input  wire logic          core_clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          in_valid_i,
  input  wire logic [DW-1:0] in_data_i,
  output logic               in_ready_o,
  output logic               out_valid_o,
  output logic [DW-1:0]      out_data_o,
  input  wire logic          out_ready_i
);
  logic          skid_v_q;  // second entry holds a word
  logic [DW-1:0] skid_q;    // second entry
  logic          push;      // word taken on the fill side
  logic          pop;       // word leaves on the drain side

  assign push = in_valid_i && in_ready_o;
  assign pop  = out_valid_o && out_ready_i;

  // ready is registered, so it falls only once the spare entry is used
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
      skid_v_q    <= 1'b0;
      skid_q      <= '0;
      in_ready_o  <= 1'b1;
    end else if (pop || !out_valid_o) begin
      // head is free: refill from spare first to keep order
      if (skid_v_q) begin
        out_data_o  <= skid_q;
        out_valid_o <= 1'b1;
        skid_v_q    <= 1'b0;
        in_ready_o  <= 1'b1;
      end else begin
        out_data_o  <= in_data_i;
        out_valid_o <= push;
      end
    end else if (push) begin
      // head stalled: park the word
      skid_q     <= in_data_i;
      skid_v_q   <= 1'b1;
      in_ready_o <= 1'b0;
    end
  end
endmodule

// ==== design/sdcs_core.sv ====
module sdcs_core
  import sdcs_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        in_valid_i,
  input  wire logic [7:0]  in_data_i,
  input  wire logic        in_last_i,
  output logic             in_ready_o,
  output logic             out_valid_o,
  output logic [7:0]       out_data_o,
  output logic             out_last_o,
  input  wire logic        out_ready_i,
  input  wire logic [7:0]  sock_open_i,
  input  wire logic [7:0]  sock_udp_i,
  output logic             conn_req_o,
  output logic [7:0]       conn_sock_o,
  output logic [15:0]      conn_port_o,
  output logic [31:0]      conn_addr_o,
  output logic             conn_text_o,
  input  wire logic        conn_done_i,
  input  wire logic [7:0]  conn_done_sock_i,
  input  wire logic        conn_ok_i,
  input  wire logic [31:0] conn_addr_i,
  output logic             close_req_o,
  output logic [7:0]       close_mask_o,
  output logic             pay_valid_o,
  output logic [7:0]       pay_data_o,
  output logic [7:0]       pay_sock_o,
  output logic             pay_name_o,
  input  wire logic        rx_chk_i,
  input  wire logic [7:0]  rx_sock_i,
  input  wire logic [31:0] rx_addr_i,
  input  wire logic [15:0] rx_port_i,
  output logic             rx_pass_o,
  output logic             rx_drop_o
);
  sdcs_state_t       state_q, state_d;    // parser state
  logic [7:0]        ftype_q, ref_q;      // request type and reference
  logic [7:0]        sock_q, atype_q;     // socket id, address type
  logic [10:0]       idx_q;               // body byte count
  logic [15:0]       port_q;              // destination port
  logic [31:0]       addr_q;              // binary destination address
  logic [NSOCK-1:0]  busy_q, up_q;        // connecting, connected
  logic [31:0]       raddr_q [NSOCK];     // connected remote address
  logic [15:0]       rport_q [NSOCK];     // connected remote port
  logic [7:0]        resp_q [4];          // answer frame bytes
  logic [2:0]        rlen_q, rpos_q;      // answer length, position
  logic              stat_pend_q;         // socket status frame owed
  logic [7:0]        stat_sock_q, stat_code_q;
  logic              take, push, buf_rdy; // byte handshakes
  logic              sid_ok, sock_up, sock_busy;
  logic [SIDX_W-1:0] sidx, didx, ridx;    // table indices
  logic [7:0]        conn_code;           // evaluated connect status
  logic [7:0]        send_code;           // evaluated transmit status
  logic [8:0]        buf_out;             // byte and last from buffer

  assign take      = in_valid_i && in_ready_o;
  assign sidx      = sock_q[SIDX_W-1:0];
  assign didx      = conn_done_sock_i[SIDX_W-1:0];
  assign ridx      = rx_sock_i[SIDX_W-1:0];
  assign sid_ok    = (sock_q < NSOCK_B) && sock_open_i[sidx];
  assign sock_up   = sid_ok && up_q[sidx];
  assign sock_busy = sid_ok && busy_q[sidx];
  assign push      = (state_q == S_RESP);

  // connect checks, in order of precedence
  always_comb begin
    if (!sid_ok) conn_code = ST_BAD_SOCK;
    else if (idx_q <= CP_ATYPE) conn_code = ST_BAD_PARAM;
    else if (atype_q > ATYPE_TEXT) conn_code = ST_BAD_ATYPE;
    else if (port_q == 16'h0000) conn_code = ST_BAD_PARAM;
    else if (atype_q == ATYPE_BIN && idx_q != CP_BIN_END)
      conn_code = ST_BAD_PARAM;
    else if (atype_q == ATYPE_TEXT && idx_q == CP_ADDR)
      conn_code = ST_BAD_PARAM;
    else if (sock_busy) conn_code = ST_IN_PROG;
    else if (sock_up) conn_code = ST_ALREADY;
    else conn_code = ST_OK;
  end

  // transmit status: unconnected first, then oversize payload
  always_comb begin
    if (!sock_up) send_code = TXS_NOT_CONN;
    // idx_q also counts the options byte, so 1500 payload bytes end at 1501
    else if (idx_q > MAX_PAYLOAD + 11'h001) send_code = TXS_TOO_LONG;
    else send_code = TXS_OK;
  end

  // next parser state; frames arrive already checked by the framer
  always_comb begin
    state_d = state_q;
    case (state_q)
      S_TYPE: begin
        if (take) begin
          if (in_last_i) state_d = S_TYPE;
          else if (in_data_i == T_CONN || in_data_i == T_CLOSE ||
                   in_data_i == T_SEND) state_d = S_REF;
          else state_d = S_SKIP;
        end else if (stat_pend_q) begin
          state_d = S_RESP;
        end
      end
      S_REF:  if (take) state_d = in_last_i ? S_TYPE : S_SOCK;
      S_SOCK: if (take) state_d = in_last_i ? S_EVAL : S_BODY;
      S_BODY: if (take && in_last_i) state_d = S_EVAL;
      S_SKIP: if (take && in_last_i) state_d = S_TYPE;
      S_EVAL: state_d = (ref_q == 8'h00) ? S_TYPE : S_RESP;
      S_RESP: begin
        if (buf_rdy && rpos_q == rlen_q - 3'h1) state_d = S_TYPE;
      end
      default: state_d = S_TYPE;
    endcase
  end

  // state and input ready; status frames win a gap between frames
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q    <= S_TYPE;
      in_ready_o <= 1'b0;
    end else begin
      state_q    <= state_d;
      in_ready_o <= (state_d == S_REF) || (state_d == S_SOCK) ||
                    (state_d == S_BODY) || (state_d == S_SKIP) ||
                    (state_d == S_TYPE && !stat_pend_q && !conn_done_i);
    end
  end

  // field capture in request byte order
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ftype_q <= 8'h00;
      ref_q   <= 8'h00;
      sock_q  <= 8'h00;
      atype_q <= 8'h00;
      idx_q   <= 11'h000;
      port_q  <= 16'h0000;
      addr_q  <= 32'h0000_0000;
    end else if (take) begin
      case (state_q)
        S_TYPE: ftype_q <= in_data_i;
        S_REF:  ref_q <= in_data_i;
        S_SOCK: begin
          sock_q <= in_data_i;
          idx_q  <= 11'h000;
        end
        S_BODY: begin
          if (idx_q != IDX_SAT) idx_q <= idx_q + 11'h001;
          if (ftype_q == T_CONN) begin
            // big-endian port, then type, then address
            if (idx_q == CP_PORT_HI) port_q[15:8] <= in_data_i;
            if (idx_q == CP_PORT_LO) port_q[7:0] <= in_data_i;
            if (idx_q == CP_ATYPE) atype_q <= in_data_i;
            if (idx_q >= CP_ADDR && idx_q < CP_BIN_END)
              addr_q <= {addr_q[23:0], in_data_i};
          end
        end
        default: ;
      endcase
    end
  end

  // payload and text names go out on one byte port, unbuffered
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pay_valid_o <= 1'b0;
      pay_data_o  <= 8'h00;
      pay_sock_o  <= 8'h00;
      pay_name_o  <= 1'b0;
    end else begin
      pay_data_o <= in_data_i;
      pay_sock_o <= sock_q;
      pay_name_o <= (ftype_q == T_CONN);
      // bytes past the limit or for a dead socket are dropped
      pay_valid_o <= take && state_q == S_BODY &&
        ((ftype_q == T_SEND && idx_q != 11'h000 &&
          idx_q <= MAX_PAYLOAD && sock_up) ||
         (ftype_q == T_CONN && atype_q == ATYPE_TEXT &&
          idx_q >= CP_ADDR));
    end
  end

  // socket table: connect start, completion, close
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_q       <= '0;
      up_q         <= '0;
      conn_req_o   <= 1'b0;
      conn_sock_o  <= 8'h00;
      conn_port_o  <= 16'h0000;
      conn_addr_o  <= 32'h0000_0000;
      conn_text_o  <= 1'b0;
      close_req_o  <= 1'b0;
      close_mask_o <= 8'h00;
      for (int i = 0; i < NSOCK; i++) begin
        raddr_q[i] <= 32'h0000_0000;
        rport_q[i] <= 16'h0000;
      end
    end else begin
      conn_req_o  <= 1'b0;
      close_req_o <= 1'b0;
      // outcome of the connect reported by the network side
      if (conn_done_i && conn_done_sock_i < NSOCK_B) begin
        busy_q[didx]  <= 1'b0;
        up_q[didx]    <= conn_ok_i;
        raddr_q[didx] <= conn_addr_i;
      end
      if (state_q == S_EVAL && ftype_q == T_CONN &&
          conn_code == ST_OK) begin
        busy_q[sidx]  <= 1'b1;
        rport_q[sidx] <= port_q;
        conn_req_o    <= 1'b1;
        conn_sock_o   <= sock_q;
        conn_port_o   <= port_q;
        conn_addr_o   <= addr_q;
        conn_text_o   <= (atype_q == ATYPE_TEXT);
      end
      if (state_q == S_EVAL && ftype_q == T_CLOSE) begin
        if (sock_q == SOCK_ALL) begin
          busy_q       <= '0;
          up_q         <= '0;
          close_req_o  <= 1'b1;
          close_mask_o <= sock_open_i;
        end else if (sid_ok) begin
          busy_q[sidx] <= 1'b0;
          up_q[sidx]   <= 1'b0;
          close_req_o  <= 1'b1;
          close_mask_o <= 8'h01 << sidx;
        end
      end
    end
  end

  // owed socket status; a new report beats the clear
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stat_pend_q <= 1'b0;
      stat_sock_q <= 8'h00;
      stat_code_q <= 8'h00;
    end else if (conn_done_i) begin
      stat_pend_q <= 1'b1;
      stat_sock_q <= conn_done_sock_i;
      stat_code_q <= conn_ok_i ? SS_UP : SS_FAIL;
    end else if (state_q == S_TYPE && state_d == S_RESP) begin
      stat_pend_q <= 1'b0;
    end
  end

  // answer frame assembly and byte walk into the buffer
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 4; i++) resp_q[i] <= 8'h00;
      rlen_q <= 3'h0;
      rpos_q <= 3'h0;
    end else if (state_q == S_TYPE && state_d == S_RESP) begin
      resp_q[0] <= T_SOCK_STAT;
      resp_q[1] <= stat_sock_q;
      resp_q[2] <= stat_code_q;
      rlen_q    <= LEN_TXS;
      rpos_q    <= 3'h0;
    end else if (state_q == S_EVAL) begin
      rpos_q    <= 3'h0;
      resp_q[1] <= ref_q;
      resp_q[2] <= sock_q;
      rlen_q    <= LEN_RSP;
      case (ftype_q)
        T_CONN: begin
          resp_q[0] <= T_CONN_RSP;
          resp_q[3] <= conn_code;
        end
        T_CLOSE: begin
          resp_q[0] <= T_CLOSE_RSP;
          resp_q[3] <= (sock_q == SOCK_ALL || sid_ok) ?
                       ST_OK : ST_BAD_SOCK;
        end
        default: begin
          resp_q[0] <= T_TX_STAT;
          resp_q[2] <= send_code;
          rlen_q    <= LEN_TXS;
        end
      endcase
    end else if (push && buf_rdy) begin
      rpos_q <= rpos_q + 3'h1;
    end
  end

  // filter for connected udp sockets; pulses one cycle after check
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_pass_o <= 1'b0;
      rx_drop_o <= 1'b0;
    end else begin
      rx_drop_o <= rx_chk_i && rx_sock_i < NSOCK_B && sock_udp_i[ridx] &&
                   up_q[ridx] && (rx_addr_i != raddr_q[ridx] ||
                   rx_port_i != rport_q[ridx]);
      rx_pass_o <= rx_chk_i && !(rx_sock_i < NSOCK_B &&
                   sock_udp_i[ridx] && up_q[ridx] &&
                   (rx_addr_i != raddr_q[ridx] ||
                    rx_port_i != rport_q[ridx]));
    end
  end

  // answers leave through the two-entry buffer to the framer
  sdcs_skid #(.DW(9)) u_skid (
    .core_clk_i  (core_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (push),
    .in_data_i   ({rpos_q == rlen_q - 3'h1, resp_q[rpos_q[1:0]]}),
    .in_ready_o  (buf_rdy),
    .out_valid_o (out_valid_o),
    .out_data_o  (buf_out),
    .out_ready_i (out_ready_i)
  );
  assign out_data_o = buf_out[7:0];
  assign out_last_o = buf_out[8];

  a_zero_ref_quiet: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    state_q == S_EVAL && ref_q == 8'h00 |=> state_q == S_TYPE ##1
    state_q != S_RESP || $past(stat_pend_q))
    else $error("answer sent for zero reference");
  a_conn_ack_form: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    state_q == S_EVAL && ftype_q == T_CONN && ref_q != 8'h00 |=>
    state_q == S_RESP && resp_q[0] == T_CONN_RSP &&
    resp_q[1] == $past(ref_q) && resp_q[2] == $past(sock_q))
    else $error("connect ack malformed");
  a_bad_atype: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    state_q == S_EVAL && ftype_q == T_CONN && sid_ok &&
    idx_q > CP_ATYPE && atype_q > ATYPE_TEXT |=>
    resp_q[3] == ST_BAD_ATYPE && !conn_req_o)
    else $error("bad address type not reported");
  a_close_all: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    state_q == S_EVAL && ftype_q == T_CLOSE && sock_q == SOCK_ALL &&
    !conn_done_i |=> up_q == '0 && busy_q == '0 && close_req_o)
    else $error("close all left sockets open");
  a_close_status: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    state_q == S_EVAL && ftype_q == T_CLOSE && sock_q != SOCK_ALL |=>
    resp_q[3] == ($past(sid_ok) ? ST_OK : ST_BAD_SOCK))
    else $error("close status wrong");
  a_send_unconn: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    state_q == S_EVAL && ftype_q == T_SEND && !sock_up &&
    ref_q != 8'h00 |=> resp_q[0] == T_TX_STAT &&
    resp_q[2] == TXS_NOT_CONN ##1 state_q == S_RESP)
    else $error("send on idle socket not refused");
  a_conn_start: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    state_q == S_EVAL && ftype_q == T_CONN && conn_code == ST_OK |=>
    conn_req_o && busy_q[$past(sidx)])
    else $error("connect not started");
  a_status_owed: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    conn_done_i |=> stat_pend_q && stat_sock_q == $past(conn_done_sock_i))
    else $error("socket status not queued");
  a_udp_filter: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    rx_chk_i |=> rx_drop_o != rx_pass_o)
    else $error("datagram both kept and dropped");
endmodule

// ==== dv/sdcs_host_model.sv ====
// far side: a framer that stalls at random plus a connect engine
module sdcs_host_model
  import sdcs_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        conn_req_i,
  input  wire logic [7:0]  conn_sock_i,
  input  wire logic [31:0] conn_addr_i,
  output logic             out_ready_o,
  output logic             done_o,
  output logic [7:0]       done_sock_o,
  output logic             ok_o,
  output logic [31:0]      addr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] FAIL_SOCK = 8'h04; // only this connect fails
  int wait_q;                               // cycles left to the outcome
  // back-pressure, about one stall cycle in four
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) out_ready_o <= 1'b0;
    else out_ready_o <= ($urandom_range(3) != 0);
  end
  // outcome a fixed time after the request, so a retry can overlap it
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_q      <= 0;
      done_o      <= 1'b0;
      done_sock_o <= 8'h00;
      ok_o        <= 1'b0;
      addr_o      <= 32'h0;
    end else begin
      done_o <= 1'b0;
      if (conn_req_i) begin
        wait_q      <= 60;
        done_sock_o <= conn_sock_i;
        addr_o      <= conn_addr_i;
      end else if (wait_q == 1) begin
        wait_q <= 0;
        done_o <= 1'b1;
        ok_o   <= (done_sock_o != FAIL_SOCK);
      end else if (wait_q > 1) begin
        wait_q <= wait_q - 1;
      end else if (!done_o) begin
        // idle: qualifiers change so nothing stale passes for valid
        addr_o      <= ~addr_o;
        done_sock_o <= ~done_sock_o;
        ok_o        <= ~ok_o;
      end
    end
  end
endmodule

// ==== dv/socket_connect_close_send_tb.sv ====
module socket_connect_close_send_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sdcs_pkg::*;
  typedef logic [7:0] sdcs_bq_t[$];
  logic core_clk_i, rst_n_i, in_valid_i, in_last_i, in_ready_o, out_ready_i;
  logic out_valid_o, out_last_o, conn_req_o, conn_text_o, conn_done_i;
  logic conn_ok_i, close_req_o, pay_valid_o, pay_name_o, rx_chk_i;
  logic rx_pass_o, rx_drop_o;
  logic [7:0]  in_data_i, out_data_o, sock_open_i, sock_udp_i, conn_sock_o;
  logic [7:0]  conn_done_sock_i, close_mask_o, pay_data_o, pay_sock_o;
  logic [7:0]  rx_sock_i;
  logic [15:0] conn_port_o, rx_port_i;
  logic [31:0] conn_addr_o, conn_addr_i, rx_addr_i;
  int          err_count;  // mismatches
  int          num_checks; // comparisons
  logic [8:0]  ans[$];     // answer bytes taken, last flag on top
  logic [16:0] pay[$];     // name flag, socket and byte per forward
  int          n_close;    // close pulses seen
  sdcs_core uut (.core_clk_i, .rst_n_i, .in_valid_i, .in_data_i, .in_last_i,
    .in_ready_o, .out_valid_o, .out_data_o, .out_last_o, .out_ready_i,
    .sock_open_i, .sock_udp_i, .conn_req_o, .conn_sock_o, .conn_port_o,
    .conn_addr_o, .conn_text_o, .conn_done_i, .conn_done_sock_i, .conn_ok_i,
    .conn_addr_i, .close_req_o, .close_mask_o, .pay_valid_o, .pay_data_o,
    .pay_sock_o, .pay_name_o, .rx_chk_i, .rx_sock_i, .rx_addr_i, .rx_port_i,
    .rx_pass_o, .rx_drop_o);
  sdcs_host_model host (.core_clk_i, .rst_n_i, .conn_req_i(conn_req_o),
    .conn_sock_i(conn_sock_o), .conn_addr_i(conn_addr_o),
    .out_ready_o(out_ready_i), .done_o(conn_done_i),
    .done_sock_o(conn_done_sock_i), .ok_o(conn_ok_i), .addr_o(conn_addr_i));
  // 250 MHz
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  // collectors sample before the edge's own updates land
  always @(posedge core_clk_i) begin
    if (out_valid_o === 1'b1 && out_ready_i === 1'b1)
      ans.push_back({out_last_o, out_data_o});
    if (pay_valid_o === 1'b1)
      pay.push_back({pay_name_o, pay_sock_o, pay_data_o});
    if (close_req_o === 1'b1) n_close++;
  end
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one request frame; each byte held until the handler takes it
  task automatic frame(input sdcs_bq_t f);
    int n;
    foreach (f[i]) begin
      in_valid_i <= 1'b1;
      in_data_i  <= f[i];
      in_last_i  <= (i == f.size() - 1);
      n = 0;
      do begin
        @(negedge core_clk_i);
        n++;
      end while (in_ready_o !== 1'b1 && n < 500);
      // a byte never taken counts against the run
      if (in_ready_o !== 1'b1) err_count++;
      @(posedge core_clk_i);
    end
    in_valid_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  // one whole answer frame, last flag only on its final byte
  task automatic rsp(input sdcs_bq_t e);
    int n;
    n = 0;
    while (ans.size() < e.size() && n < 2000) begin
      @(posedge core_clk_i);
      n++;
    end
    foreach (e[i])
      chk(ans.size() ? 32'(ans.pop_front()) : 32'hx,
          {23'h0, i == e.size() - 1, e[i]});
  endtask
  task automatic quiet;
    repeat (40) @(posedge core_clk_i);
    chk(ans.size(), 0);
  endtask
  // datagram check on socket 1, result one cycle later
  task automatic rx(input logic [31:0] a, input logic [15:0] p, input logic drop);
    rx_chk_i  <= 1'b1;
    rx_sock_i <= 8'h01;
    rx_addr_i <= a;
    rx_port_i <= p;
    @(posedge core_clk_i);
    rx_chk_i <= 1'b0;
    @(negedge core_clk_i);
    chk({rx_drop_o, rx_pass_o}, {drop, ~drop});
    @(posedge core_clk_i);
  endtask
  function automatic sdcs_bq_t cf(input logic [7:0] r, s, input logic [15:0] p,
                                  input logic [7:0] at, input logic [31:0] a);
    return '{T_CONN, r, s, p[15:8], p[7:0], at, a[31:24], a[23:16], a[15:8], a[7:0]};
  endfunction
  // hang guard, far beyond the few thousand cycles the run needs
  initial begin
    #200000;
    err_count++;
    final_report();
  end
  initial begin
    logic [7:0]  r;
    logic [15:0] p;
    logic [31:0] a;
    sdcs_bq_t    q;
    int          n;
    void'($urandom(32'h5c22158d));
    {rst_n_i, in_valid_i, in_last_i, rx_chk_i} = 4'h0;
    {in_data_i, rx_sock_i, rx_port_i, rx_addr_i} = '0;
    sock_open_i = 8'h1f; // sockets 0 to 4 exist
    sock_udp_i  = 8'h02; // socket 1 is udp
    repeat (20) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    frame('{T_CLOSE, 8'h05, 8'h02});
    rsp('{T_CLOSE_RSP, 8'h05, 8'h02, ST_OK});
    frame('{T_CLOSE, 8'h06, 8'h06});
    rsp('{T_CLOSE_RSP, 8'h06, 8'h06, ST_BAD_SOCK});
    frame('{T_CLOSE, 8'h00, 8'h02});
    quiet();
    // unknown type is consumed to its end and never answered
    frame('{8'h40, 8'h01, 8'h00});
    quiet();
    // plain send only on a tcp socket while it is unconnected
    frame('{T_SEND, 8'h07, 8'h00, 8'h00, 8'h55});
    rsp('{T_TX_STAT, 8'h07, TXS_NOT_CONN});
    r = 8'($urandom_range(255, 1));
    p = 16'($urandom_range(65535, 1));
    a = $urandom();
    // refused connects: bad type, zero port, missing socket
    frame(cf(8'h11, 8'h00, p, 8'h02, a));
    rsp('{T_CONN_RSP, 8'h11, 8'h00, ST_BAD_ATYPE});
    frame(cf(8'h12, 8'h00, 16'h0000, ATYPE_BIN, a));
    rsp('{T_CONN_RSP, 8'h12, 8'h00, ST_BAD_PARAM});
    frame(cf(8'h13, 8'h05, p, ATYPE_BIN, a));
    rsp('{T_CONN_RSP, 8'h13, 8'h05, ST_BAD_SOCK});
    frame(cf(r, 8'h01, p, ATYPE_BIN, a));
    rsp('{T_CONN_RSP, r, 8'h01, ST_OK});
    chk(32'(conn_port_o), 32'(p));
    chk(conn_addr_o, a);
    chk(32'(conn_text_o), 32'h0);
    rsp('{T_SOCK_STAT, 8'h01, SS_UP});
    frame(cf(8'h14, 8'h01, p, ATYPE_BIN, a));
    rsp('{T_CONN_RSP, 8'h14, 8'h01, ST_ALREADY});
    // a retry while the first attempt is still running
    frame(cf(8'h21, 8'h03, p, ATYPE_BIN, a));
    frame(cf(8'h22, 8'h03, p, ATYPE_BIN, a));
    rsp('{T_CONN_RSP, 8'h21, 8'h03, ST_OK});
    rsp('{T_CONN_RSP, 8'h22, 8'h03, ST_IN_PROG});
    rsp('{T_SOCK_STAT, 8'h03, SS_UP});
    frame(cf(8'h31, 8'h04, p, ATYPE_BIN, a));
    rsp('{T_CONN_RSP, 8'h31, 8'h04, ST_OK});
    rsp('{T_SOCK_STAT, 8'h04, SS_FAIL});
    // silent ack, yet the status frame still follows
    frame(cf(8'h00, 8'h00, p, ATYPE_BIN, a));
    rsp('{T_SOCK_STAT, 8'h00, SS_UP});
    pay.delete();
    frame('{T_CONN, 8'h41, 8'h02, 8'h00, 8'h35, ATYPE_TEXT, 8'h61, 8'h2e, 8'h62});
    rsp('{T_CONN_RSP, 8'h41, 8'h02, ST_OK});
    chk(32'(conn_text_o), 32'h1);
    chk(pay.size(), 3);
    chk(32'(pay[0]), 32'h0001_0261);
    chk(32'(pay[2]), 32'h0001_0262);
    rsp('{T_SOCK_STAT, 8'h02, SS_UP});
    pay.delete();
    q = '{T_SEND, 8'h04, 8'h01, 8'h00};
    n = $urandom_range(8, 1);
    repeat (n) q.push_back(8'($urandom()));
    frame(q);
    rsp('{T_TX_STAT, 8'h04, TXS_OK});
    chk(pay.size(), n);
    foreach (pay[i]) chk(32'(pay[i]), {15'h0, 9'h001, q[i + 4]});
    frame('{T_SEND, 8'h00, 8'h01, 8'h00, 8'h12});
    quiet();
    // payload at the limit passes, one byte more is refused
    q = '{T_SEND, 8'h0b, 8'h01, 8'h00};
    repeat (1500) q.push_back(8'($urandom()));
    pay.delete();
    frame(q);
    rsp('{T_TX_STAT, 8'h0b, TXS_OK});
    chk(pay.size(), 1500);
    q.push_back(8'h5a);
    q[1] = 8'h0c;
    pay.delete();
    frame(q);
    rsp('{T_TX_STAT, 8'h0c, TXS_TOO_LONG});
    chk(pay.size(), 1500);
    rx(a, p, 1'b0);
    rx(~a, p, 1'b1);
    rx(a, ~p, 1'b1);
    frame('{T_CLOSE, 8'h09, SOCK_ALL});
    rsp('{T_CLOSE_RSP, 8'h09, SOCK_ALL, ST_OK});
    chk(32'(close_mask_o & sock_open_i), 32'(sock_open_i));
    chk(n_close, 3);
    // tcp socket 3 was up until the close of all
    frame('{T_SEND, 8'h0a, 8'h03, 8'h00, 8'h77});
    rsp('{T_TX_STAT, 8'h0a, TXS_NOT_CONN});
    final_report();
  end
endmodule
